// ===== rtl/tss_alert.sv
// Temperature alert output: interrupt, comparator and critical-only behaviour
`timescale 1ns/1ps
module tss_alert
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Configuration
	input  wire logic       alert_enable,
	input  wire logic [1:0] alert_mode,
	input  wire logic       alert_active_high,
	input  wire logic       clear_event,
	// Limit comparisons from the sensor
	input  wire logic       above_high_limit,
	input  wire logic       below_low_limit,
	input  wire logic       above_critical_limit,
	input  wire logic       below_critical_hyst,
	// Open-drain alert pin
	output logic            alert_out,
	output logic            alert_oe,
	output logic            alert_asserted
);
	typedef struct packed
	{
		logic crit_latch;
		logic win_q;
		logic sticky;
		logic asserted;
		logic oe;
	} tss_al_t;

	tss_al_t r;
	tss_al_t next_r;
	logic    win;

	always_comb
	begin
		next_r = r;
		win = above_high_limit | below_low_limit;
		next_r.win_q = win;
		// Critical compare always releases on its own below the hysteresis point
		if (above_critical_limit)
			next_r.crit_latch = 1'b1;
		else if (below_critical_hyst)
			next_r.crit_latch = 1'b0;
		// A new window event in the clearing cycle still sets the flag
		if (win && !r.win_q)
			next_r.sticky = 1'b1;
		else if (clear_event)
			next_r.sticky = 1'b0;
		unique case (alert_mode)
			tss_pkg::MODE_INT:  next_r.asserted = next_r.sticky | next_r.crit_latch;
			tss_pkg::MODE_CRIT: next_r.asserted = next_r.crit_latch;
			default:            next_r.asserted = win | next_r.crit_latch;
		endcase
		if (!alert_enable)
			next_r.asserted = 1'b0;
		// Pin is only ever pulled low; active high means low while idle
		next_r.oe = next_r.asserted ^ alert_active_high;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '{crit_latch: 1'b0, win_q: 1'b0, sticky: 1'b0, asserted: 1'b0, oe: 1'b0};
		else
			r <= next_r;
	end

	assign alert_out      = 1'b0;
	assign alert_oe       = r.oe;
	assign alert_asserted = r.asserted;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	int_hold_a: assert property ((r.asserted && alert_mode == tss_pkg::MODE_INT && alert_enable
		&& !clear_event && !below_critical_hyst) ##1 (alert_mode == tss_pkg::MODE_INT
		&& alert_enable) |-> r.asserted) else $error("interrupt alert dropped without clear");
	crit_only_a: assert property ((alert_mode == tss_pkg::MODE_CRIT)
		|=> r.asserted == (r.crit_latch && $past(alert_enable)))
		else $error("critical-only alert not following critical latch");
	crit_hyst_a: assert property ((r.crit_latch && !below_critical_hyst) |=> r.crit_latch)
		else $error("critical alert released above hysteresis point");
	polarity_a: assert property (r.oe == (r.asserted ^ $past(alert_active_high)))
		else $error("alert pin level does not match polarity");
endmodule : tss_alert

// ===== rtl/tss_deglitch.sv
// Two-flop synchroniser followed by a stability filter for one pin
`timescale 1ns/1ps
module tss_deglitch
#(
	parameter logic INIT = 1'b1
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Pin and clean level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed
	{
		logic       sync1;
		logic       sync2;
		logic       level;
		logic [1:0] cnt;
	} tss_dg_t;

	tss_dg_t r;
	tss_dg_t next_r;

	always_comb
	begin
		next_r = r;
		next_r.sync1 = pin;
		next_r.sync2 = r.sync1;
		// Short pulses never reach the count, so they are not seen as edges
		if (r.sync2 == r.level)
			next_r.cnt = 2'h0;
		else if (r.cnt == tss_pkg::FILT_LEN - 2'h1)
		begin
			next_r.level = r.sync2;
			next_r.cnt   = 2'h0;
		end
		else
			next_r.cnt = r.cnt + 2'h1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '{sync1: INIT, sync2: INIT, level: INIT, cnt: 2'h0};
		else
			r <= next_r;
	end

	assign level = r.level;
endmodule : tss_deglitch

// ===== rtl/tss_pkg.sv
// Shared constants for the thermal and serial presence slave front end
package tss_pkg;
	// Device type codes in the upper nibble of the address byte
	localparam logic [3:0] NV_TYPE_CODE   = 4'hA;
	localparam logic [3:0] PROT_TYPE_CODE = 4'h6;
	localparam logic [3:0] TS_TYPE_CODE   = 4'h3;
	// Select codes that steer the page commands, which need no elevated strap
	localparam logic [1:0] PAGE_SEL_HI    = 2'h3;
	// Access targets reported with each accepted address
	localparam logic [1:0] TGT_NONE       = 2'h0;
	localparam logic [1:0] TGT_NV         = 2'h1;
	localparam logic [1:0] TGT_PROT       = 2'h2;
	localparam logic [1:0] TGT_TS         = 2'h3;
	// Samples a pin must hold before its filtered level follows
	localparam logic [1:0] FILT_LEN       = 2'h3;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	// Alert output behaviour
	localparam logic [1:0] MODE_INT       = 2'h0;
	localparam logic [1:0] MODE_CMP       = 2'h1;
	localparam logic [1:0] MODE_CRIT      = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_MACK = 3'b100
	} tss_state_t;
endpackage : tss_pkg

// ===== rtl/tss_slave.sv
// Two-wire slave front end with address decode and alert output
`timescale 1ns/1ps
module tss_slave
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Serial bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Address straps and elevated level detector on strap 0
	input  wire logic       addr_strap_0,
	input  wire logic       addr_strap_1,
	input  wire logic       addr_strap_2,
	input  wire logic       elevated_strap_level,
	// Memory and sensor side
	input  wire logic       nv_write_busy,
	input  wire logic       write_refused,
	input  wire logic [7:0] tx_data,
	output logic            addr_valid,
	output logic [1:0]      addr_target,
	output logic            addr_read,
	output logic [2:0]      addr_sel,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic [3:0]      byte_index,
	output logic            tx_req,
	output logic            nv_write_launch,
	output logic            nv_standby,
	// Alert configuration and limit comparisons
	input  wire logic       alert_enable,
	input  wire logic [1:0] alert_mode,
	input  wire logic       alert_active_high,
	input  wire logic       clear_event,
	input  wire logic       above_high_limit,
	input  wire logic       below_low_limit,
	input  wire logic       above_critical_limit,
	input  wire logic       below_critical_hyst,
	// Open-drain alert pin
	output logic            alert_out,
	output logic            alert_oe,
	output logic            alert_asserted
);
	typedef struct packed
	{
		tss_pkg::tss_state_t state;
		logic [3:0]          bitcnt;
		logic [7:0]          shreg;
		logic                is_addr;
		logic [1:0]          target;
		logic                rd;
		logic                rd_ack;
		logic [3:0]          index;
		logic                scl_q;
		logic                sda_q;
		logic                nv_wrote;
		logic                nv_nacked;
		logic                sda_oe;
		logic                addr_valid;
		logic [1:0]          addr_target;
		logic                addr_read;
		logic [2:0]          addr_sel;
		logic                rx_valid;
		logic [7:0]          rx_byte;
		logic [3:0]          rx_index;
		logic                tx_req;
		logic                nv_launch;
		logic                nv_standby;
	} tss_core_t;
	tss_core_t  r;
	tss_core_t  next_r;
	logic [5:0] pins;
	logic [5:0] clean;
	logic       scl_f;
	logic       sda_f;
	logic [2:0] logical_select_addr;
	logic       hv_f;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic [3:0] code;
	logic [2:0] sel;
	logic       hit_nv;
	logic       hit_ts;
	logic       hit_pr;
	assign pins = {elevated_strap_level, addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl_in};
	for (genvar gi = 0; gi < 6; gi++)
	begin : g_pin
		tss_deglitch #(.INIT(1'b1)) u_dg
		(
			.clk    (clk),
			.resetn (resetn),
			.pin    (pins[gi]),
			.level  (clean[gi])
		);
	end
	// Clock is only ever sampled here, never driven, so no stretching is possible
	assign scl_f    = clean[0];
	assign sda_f    = clean[1];
	assign logical_select_addr      = clean[4:2];
	assign hv_f     = clean[5];
	assign scl_rise = scl_f && !r.scl_q;
	assign scl_fall = !scl_f && r.scl_q;
	assign start_ev = r.scl_q && scl_f && r.sda_q && !sda_f;
	assign stop_ev  = r.scl_q && scl_f && !r.sda_q && sda_f;
	assign code     = r.shreg[7:4];
	assign sel      = r.shreg[3:1];
	assign hit_nv   = (code == tss_pkg::NV_TYPE_CODE) && (sel == logical_select_addr);
	assign hit_ts   = (code == tss_pkg::TS_TYPE_CODE) && (sel == logical_select_addr);
	// Protection reads, page commands and elevated-strap protect writes are taken by every device regardless of select
	assign hit_pr   = (code == tss_pkg::PROT_TYPE_CODE)
		&& (r.shreg[0] || sel[2:1] == tss_pkg::PAGE_SEL_HI || hv_f);
	always_comb
	begin
		next_r = r;
		next_r.addr_valid = 1'b0;
		next_r.rx_valid   = 1'b0;
		next_r.tx_req     = 1'b0;
		next_r.nv_launch  = 1'b0;
		next_r.scl_q      = scl_f;
		next_r.sda_q      = sda_f;
		if (start_ev && !nv_write_busy)
		begin
			next_r.state     = tss_pkg::ST_RX;
			next_r.bitcnt    = 4'h0;
			next_r.is_addr   = 1'b1;
			next_r.sda_oe    = 1'b0;
			next_r.index     = 4'h0;
			next_r.nv_wrote  = 1'b0;
			next_r.nv_nacked = 1'b0;
		end
		else if (stop_ev)
		begin
			next_r.state  = tss_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
			// Sensor traffic leaves the memory outputs alone
			if (r.target == tss_pkg::TGT_NV)
			begin
				next_r.nv_launch = r.nv_wrote;
				if (r.nv_nacked)
					next_r.nv_standby = 1'b1;
			end
			next_r.target = tss_pkg::TGT_NONE;
		end
		else if (start_ev)
		begin
			// Write cycle running: stay silent until a later start
			next_r.state  = tss_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
		end
		else
		begin
			unique case (r.state)
				tss_pkg::ST_IDLE: next_r.sda_oe = 1'b0;
				tss_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						next_r.shreg  = {r.shreg[6:0], sda_f};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
					else if (scl_fall && r.bitcnt == tss_pkg::BITS_PER_BYTE)
					begin
						if (r.is_addr)
						begin
							if (hit_nv || hit_ts || hit_pr)
							begin
								next_r.state       = tss_pkg::ST_ACK;
								next_r.sda_oe      = 1'b1;
								next_r.is_addr     = 1'b0;
								next_r.rd          = r.shreg[0];
								next_r.target      = hit_nv ? tss_pkg::TGT_NV :
									hit_ts ? tss_pkg::TGT_TS : tss_pkg::TGT_PROT;
								next_r.addr_valid  = 1'b1;
								next_r.addr_target = next_r.target;
								next_r.addr_read   = r.shreg[0];
								next_r.addr_sel    = sel;
								next_r.tx_req      = r.shreg[0];
								if (hit_nv)
									next_r.nv_standby = 1'b0;
							end
							else
							begin
								next_r.state = tss_pkg::ST_IDLE;
								if (code == tss_pkg::NV_TYPE_CODE)
									next_r.nv_standby = 1'b1;
							end
						end
						else
						begin
							next_r.state    = tss_pkg::ST_ACK;
							next_r.rx_valid = 1'b1;
							next_r.rx_byte  = r.shreg;
							next_r.rx_index = r.index;
							next_r.index    = (r.index == 4'hF) ? r.index : r.index + 4'h1;
							next_r.sda_oe   = !write_refused;
							if (!write_refused && r.target == tss_pkg::TGT_NV)
								next_r.nv_wrote = 1'b1;
						end
					end
				end
				tss_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						next_r.bitcnt = 4'h0;
						if (r.rd)
						begin
							next_r.state  = tss_pkg::ST_TX;
							next_r.sda_oe = !tx_data[7];
							next_r.shreg  = {tx_data[6:0], 1'b0};
							next_r.bitcnt = 4'h1;
						end
						else
						begin
							next_r.state  = tss_pkg::ST_RX;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				tss_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						if (r.bitcnt == tss_pkg::BITS_PER_BYTE)
						begin
							next_r.sda_oe = 1'b0;
							next_r.state  = tss_pkg::ST_MACK;
						end
						else
						begin
							next_r.sda_oe = !r.shreg[7];
							next_r.shreg  = {r.shreg[6:0], 1'b0};
							next_r.bitcnt = r.bitcnt + 4'h1;
						end
					end
				end
				tss_pkg::ST_MACK:
				begin
					if (scl_rise)
					begin
						next_r.rd_ack = !sda_f;
						next_r.tx_req = !sda_f;
						if (!sda_f)
							next_r.index = (r.index == 4'hF) ? r.index : r.index + 4'h1;
					end
					else if (scl_fall)
					begin
						if (r.rd_ack)
						begin
							next_r.state  = tss_pkg::ST_TX;
							next_r.sda_oe = !tx_data[7];
							next_r.shreg  = {tx_data[6:0], 1'b0};
							next_r.bitcnt = 4'h1;
						end
						else
						begin
							// Nack closes the read; wait quietly for the stop
							next_r.state     = tss_pkg::ST_IDLE;
							next_r.nv_nacked = (r.target == tss_pkg::TGT_NV);
						end
					end
				end
				default:
				begin
					next_r.state  = tss_pkg::ST_IDLE;
					next_r.sda_oe = 1'b0;
				end
			endcase
		end
		next_r.rx_index = next_r.rx_valid ? next_r.rx_index : next_r.index;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '{state: tss_pkg::ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		else
			r <= next_r;
	end
	// Sensor section is independent of the memory state above
	tss_alert u_alert
	(
		.clk                  (clk),
		.resetn               (resetn),
		.alert_enable         (alert_enable),
		.alert_mode           (alert_mode),
		.alert_active_high    (alert_active_high),
		.clear_event          (clear_event),
		.above_high_limit     (above_high_limit),
		.below_low_limit      (below_low_limit),
		.above_critical_limit (above_critical_limit),
		.below_critical_hyst  (below_critical_hyst),
		.alert_out            (alert_out),
		.alert_oe             (alert_oe),
		.alert_asserted       (alert_asserted)
	);
	assign sda_out         = 1'b0;
	assign sda_oe          = r.sda_oe;
	assign addr_valid      = r.addr_valid;
	assign addr_target     = r.addr_target;
	assign addr_read       = r.addr_read;
	assign addr_sel        = r.addr_sel;
	assign rx_valid        = r.rx_valid;
	assign rx_byte         = r.rx_byte;
	assign byte_index      = r.rx_index;
	assign tx_req          = r.tx_req;
	assign nv_write_launch = r.nv_launch;
	assign nv_standby      = r.nv_standby;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence start_seq;
		r.scl_q && scl_f && r.sda_q && !sda_f;
	endsequence
	sequence stop_seq;
		r.scl_q && scl_f && !r.sda_q && sda_f;
	endsequence
	sequence addr_done_seq;
		r.state == tss_pkg::ST_RX && r.is_addr && scl_fall && r.bitcnt == 4'h8;
	endsequence
	start_go_a: assert property ((start_seq and !nv_write_busy) |=>
		(r.state == tss_pkg::ST_RX && r.is_addr && r.bitcnt == 4'h0))
		else $error("start not taken");
	busy_quiet_a: assert property ((r.state == tss_pkg::ST_IDLE && nv_write_busy) |=>
		(r.state == tss_pkg::ST_IDLE && !r.sda_oe))
		else $error("device woke during write cycle");
	stop_end_a: assert property (stop_seq |=> (r.state == tss_pkg::ST_IDLE && !r.sda_oe))
		else $error("stop did not end the transfer");
	drive_when_a: assert property (r.sda_oe |-> (r.state inside {tss_pkg::ST_ACK, tss_pkg::ST_TX}))
		else $error("data line pulled outside ack or transmit");
	addr_ack_a: assert property (r.addr_valid |-> (r.sda_oe && r.state == tss_pkg::ST_ACK))
		else $error("accepted address without ack");
	mismatch_a: assert property ((addr_done_seq and (code == tss_pkg::NV_TYPE_CODE
		&& sel != logical_select_addr)) |=> (r.nv_standby && !r.sda_oe && r.state == tss_pkg::ST_IDLE))
		else $error("memory mismatch not in standby");
	prot_hv_a: assert property ((r.addr_valid && r.addr_target == tss_pkg::TGT_PROT
		&& !r.addr_read && r.addr_sel[2:1] != tss_pkg::PAGE_SEL_HI) |-> $past(hv_f))
		else $error("protect change taken without elevated strap");
	launch_a: assert property (r.nv_launch |-> ($past(r.nv_wrote) && $past(stop_ev)))
		else $error("write cycle launched without stop after write");
endmodule : tss_slave

// ===== verification/thermal_spd_serial_slave_front_end_bench.sv
// Self-checking bench for the two-wire slave front end and alert output
`timescale 1ns/1ps
module thermal_spd_serial_slave_front_end_bench;
	logic       clk, resetn, scl, sda_pull, sda_line, sda_out, sda_oe;
	logic       addr_strap_0, addr_strap_1, addr_strap_2, elevated_strap_level;
	logic       nv_write_busy, write_refused, addr_valid, addr_read, rx_valid, tx_req;
	logic       nv_write_launch, nv_standby, seen_rd, ack;
	logic [7:0] tx_data, rx_byte, seen_rx, q;
	logic [7:0] tx_bytes [2];
	logic [1:0] addr_target, seen_tgt, alert_mode;
	logic [2:0] addr_sel;
	logic [3:0] byte_index;
	logic       alert_enable, alert_active_high, clear_event, above_high_limit;
	logic       below_low_limit, above_critical_limit, below_critical_hyst;
	logic       alert_out, alert_oe, alert_asserted;
	int         launches, tx_idx, cycles, fail_count, num_checks;
	// Each step: mode, clear, {high, low, critical, below hysteresis}, expected alert
	logic [7:0] steps [12] = '{8'b0001_0001, 8'b0000_0001, 8'b0010_0000, 8'b0011_0001,
		8'b0101_0001, 8'b0100_0000, 8'b0100_1001, 8'b0100_0000, 8'b1001_0000,
		8'b1000_0101, 8'b1000_0001, 8'b1000_0010};

	// Data line has a pull-up: released means high
	assign sda_line = ~(sda_pull | sda_oe);

	tss_host_model h (.clk, .sda_line, .scl, .sda_pull);

	tss_slave dut (.clk, .resetn, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
		.addr_strap_0, .addr_strap_1, .addr_strap_2, .elevated_strap_level,
		.nv_write_busy, .write_refused, .tx_data, .addr_valid, .addr_target, .addr_read,
		.addr_sel, .rx_valid, .rx_byte, .byte_index, .tx_req, .nv_write_launch,
		.nv_standby, .alert_enable, .alert_mode, .alert_active_high, .clear_event,
		.above_high_limit, .below_low_limit, .above_critical_limit, .below_critical_hyst,
		.alert_out, .alert_oe, .alert_asserted);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	always @(posedge clk)
	begin
		if (addr_valid)
		begin
			seen_tgt <= addr_target;
			seen_rd <= addr_read;
		end
		if (rx_valid)
			seen_rx <= rx_byte;
		if (nv_write_launch)
			launches <= launches + 1;
		if (tx_req)
		begin
			tx_data <= tx_bytes[tx_idx % 2];
			tx_idx <= tx_idx + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			fail_count++;
			close_out();
		end
	end

	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Straps pass a filter, so give them time to settle
	task set_straps(input logic [2:0] s, input logic hv);
		{addr_strap_2, addr_strap_1, addr_strap_0} <= s;
		elevated_strap_level <= hv;
		h.tick(10);
	endtask : set_straps

	task addr(input logic [7:0] a);
		h.start();
		h.xfer(a, 1'b1, q, ack);
	endtask : addr

	task t_mem_write;
		int n;
		set_straps(3'h0, 1'b0);
		addr(8'hA0);
		chk("address ack", {7'h00, ack}, 8'h00);
		chk("target", {6'h00, seen_tgt}, {6'h00, tss_pkg::TGT_NV});
		chk("direction", {7'h00, seen_rd}, 8'h00);
		h.xfer(8'h5A, 1'b1, q, ack);
		chk("data ack", {7'h00, ack}, 8'h00);
		chk("received byte", seen_rx, 8'h5A);
		chk("byte index", {4'h0, byte_index}, 8'h01);
		chk("drive level", {7'h00, sda_out}, 8'h00);
		n = launches;
		h.stop();
		h.tick(4);
		chk("write launch", 8'(launches), 8'(n + 1));
		write_refused <= 1'b1;
		addr(8'hA0);
		h.xfer(8'h33, 1'b1, q, ack);
		chk("refused ack", {7'h00, ack}, 8'h01);
		h.stop();
		write_refused <= 1'b0;
		$display("test mem_write done");
	endtask : t_mem_write

	task t_select;
		set_straps(3'h7, 1'b0);
		addr(8'hA0);
		chk("mismatch ack", {7'h00, ack}, 8'h01);
		h.stop();
		h.tick(4);
		chk("standby", {7'h00, nv_standby}, 8'h01);
		addr(8'hAE);
		chk("match ack", {7'h00, ack}, 8'h00);
		chk("select", {5'h00, addr_sel}, 8'h07);
		chk("standby left", {7'h00, nv_standby}, 8'h00);
		h.stop();
		addr(8'h5A);
		chk("unknown code ack", {7'h00, ack}, 8'h01);
		h.stop();
		nv_write_busy <= 1'b1;
		addr(8'hAE);
		chk("busy ack", {7'h00, ack}, 8'h01);
		h.stop();
		nv_write_busy <= 1'b0;
		$display("test select done");
	endtask : t_select

	task t_protect;
		addr(8'h62);
		chk("protect no hv ack", {7'h00, ack}, 8'h01);
		h.stop();
		set_straps(3'h5, 1'b1);
		addr(8'h62);
		chk("protect hv ack", {7'h00, ack}, 8'h00);
		chk("target", {6'h00, seen_tgt}, {6'h00, tss_pkg::TGT_PROT});
		h.stop();
		set_straps(3'h5, 1'b0);
		addr(8'h6C);
		chk("page ack", {7'h00, ack}, 8'h00);
		h.stop();
		$display("test protect done");
	endtask : t_protect

	task t_sensor_read;
		set_straps(3'h0, 1'b0);
		tx_bytes[0] = 8'hC3;
		tx_bytes[1] = 8'h5A;
		tx_idx <= 0;
		addr(8'h31);
		chk("sensor ack", {7'h00, ack}, 8'h00);
		chk("target", {6'h00, seen_tgt}, {6'h00, tss_pkg::TGT_TS});
		chk("direction", {7'h00, seen_rd}, 8'h01);
		h.xfer(8'hFF, 1'b0, q, ack);
		chk("high byte", q, 8'hC3);
		h.xfer(8'hFF, 1'b1, q, ack);
		chk("low byte", q, 8'h5A);
		h.stop();
		addr(8'hA1);
		h.xfer(8'hFF, 1'b1, q, ack);
		chk("memory read byte", q, 8'hC3);
		h.stop();
		h.tick(4);
		chk("read standby", {7'h00, nv_standby}, 8'h01);
		$display("test sensor_read done");
	endtask : t_sensor_read

	task t_alert;
		alert_active_high <= 1'b0;
		foreach (steps[i])
		begin
			alert_mode <= {1'b0, steps[i][7]} << 1 | {1'b0, steps[i][6]};
			{above_high_limit, below_low_limit, above_critical_limit, below_critical_hyst}
				<= steps[i][4:1];
			clear_event <= steps[i][5];
			h.tick(1);
			clear_event <= 1'b0;
			h.tick(4);
			chk("alert", {7'h00, alert_asserted}, {7'h00, steps[i][0]});
			chk("alert pin", {7'h00, alert_oe}, {7'h00, steps[i][0]});
		end
		alert_mode <= tss_pkg::MODE_CMP;
		alert_active_high <= 1'b1;
		above_high_limit <= 1'b1;
		h.tick(5);
		chk("alert high", {6'h00, alert_asserted, alert_oe}, 8'h02);
		chk("alert drive", {7'h00, alert_out}, 8'h00);
		alert_enable <= 1'b0;
		h.tick(5);
		chk("alert disabled", {6'h00, alert_asserted, alert_oe}, 8'h01);
		$display("test alert done");
	endtask : t_alert

	initial
	begin
		resetn = 1'b0;
		{addr_strap_0, addr_strap_1, addr_strap_2, elevated_strap_level} = 4'h0;
		{nv_write_busy, write_refused, clear_event, alert_active_high} = 4'h0;
		{above_high_limit, below_low_limit, above_critical_limit} = 3'h0;
		below_critical_hyst = 1'b0;
		alert_enable = 1'b1;
		alert_mode = tss_pkg::MODE_INT;
		tx_data = 8'h00;
		{launches, tx_idx, cycles, fail_count, num_checks} = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		h.tick(10);
		t_mem_write();
		t_select();
		t_protect();
		t_sensor_read();
		t_alert();
		close_out();
	end
endmodule : thermal_spd_serial_slave_front_end_bench

// ===== verification/tss_host_model.sv
// Bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module tss_host_model
(
	// Clock
	input  wire logic clk,
	// Bus wires
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Low half is stretched past the slave's filter delay so its data settles before the rise
	task start;
		tick(6);
		sda_pull <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_pull <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask : start

	task stop;
		tick(6);
		sda_pull <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_pull <= 1'b0;
		tick(4);
	endtask : stop

	// One clock pulse; the bus is read at the end of the high half
	task bit_io(input logic b, output logic s);
		tick(6);
		sda_pull <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		s = sda_line;
		scl <= 1'b0;
	endtask : bit_io

	// Eight bits then the ninth; send 8'hFF to read, last low to acknowledge
	task xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, ack);
	endtask : xfer
endmodule : tss_host_model
